// ### logic/ieu_pkg.sv
// Shared constants, operation codes and helper functions for the unit
package ieu_pkg;

  // ************************************************************
  // Operand sizes
  // ************************************************************
  localparam logic [1:0] SIZE_BYTE = 2'h0;   // 8-bit operand
  localparam logic [1:0] SIZE_WORD = 2'h1;   // 16-bit operand
  localparam logic [1:0] SIZE_LONG = 2'h2;   // 32-bit operand

  // ************************************************************
  // Constants
  // ************************************************************
  localparam logic [31:0] SAT_MOST_NEG = 32'h80000000; // Saturate low
  localparam logic [31:0] SAT_MOST_POS = 32'h7FFFFFFF; // Saturate high
  localparam logic [5:0]  FF1_NONE     = 6'h20;        // No one bit found
  localparam logic [31:0] STACK_STEP   = 32'h00000004; // Push size
  localparam int          TSET_BIT     = 7;            // Bit set by test
  localparam int          FLAG_C       = 0;            // Carry position
  localparam int          FLAG_V       = 1;            // Overflow position
  localparam int          FLAG_Z       = 2;            // Zero position
  localparam int          FLAG_N       = 3;            // Negative position
  localparam logic [31:0] RST_WORD     = 32'h00000000; // Reset of words

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    OP_BIT_REVERSE    = 4'h0,
    OP_BYTE_SWAP      = 4'h1,
    OP_FIND_FIRST_ONE = 4'h2,
    OP_ICACHE_LOCK    = 4'h3,
    OP_QUICK_IMM_MOVE = 4'h4,
    OP_TO_USER_SP     = 4'h5,
    OP_FROM_USER_SP   = 4'h6,
    OP_SIGN_EXT_MOVE  = 4'h7,
    OP_ZERO_EXT_MOVE  = 4'h8,
    OP_SIGNED_SAT     = 4'h9,
    OP_TEST_SET_BYTE  = 4'hA,
    OP_BRANCH_LONG    = 4'hB,
    OP_SUBR_CALL_LONG = 4'hC,
    OP_COMPARE        = 4'hD,
    OP_COMPARE_IMM    = 4'hE,
    OP_IMM_STORE_DISP = 4'hF
  } ieu_op_type;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_TSET_RD = 5'h02,
    ST_MEM_WR  = 5'h04,
    ST_PUSH    = 5'h08,
    ST_LOCK    = 5'h10
  } ieu_state_type;

  // ************************************************************
  // Functions
  // ************************************************************
  // Sign-extend a byte or word to a longword
  function automatic logic [31:0] ieu_sext(input logic [1:0]  size,
                                           input logic [31:0] val);
    if (size == SIZE_BYTE) begin
      return {{24{val[7]}}, val[7:0]};
    end else if (size == SIZE_WORD) begin
      return {{16{val[15]}}, val[15:0]};
    end
    return val;
  endfunction : ieu_sext

  // Zero-extend a byte or word to a longword
  function automatic logic [31:0] ieu_zext(input logic [1:0]  size,
                                           input logic [31:0] val);
    if (size == SIZE_BYTE) begin
      return {24'h000000, val[7:0]};
    end else if (size == SIZE_WORD) begin
      return {16'h0000, val[15:0]};
    end
    return val;
  endfunction : ieu_zext

endpackage : ieu_pkg

// ### logic/ieu_bit_ops.sv
// Bit reverse, byte swap and find-first-one datapath
`timescale 1ns/1ps
`default_nettype none
module ieu_bit_ops
  import ieu_pkg::*;
(
  // Operand
  input  wire logic [31:0] value_i,
  // Results
  output logic      [31:0] rev_o,
  output logic      [31:0] swap_o,
  output logic      [5:0]  ff1_o
);

  // ************************************************************
  // Combinational results
  // ************************************************************
  // Mirror bits and bytes, scan from the top for the first one
  always_comb begin
    rev_o  = RST_WORD;
    ff1_o  = FF1_NONE;
    swap_o = {value_i[7:0], value_i[15:8],
              value_i[23:16], value_i[31:24]};
    for (int i = 0; i < 32; i++) begin
      rev_o[i] = value_i[31-i];
      if (value_i[i]) begin
        ff1_o = 6'(31 - i);
      end
    end
  end

endmodule : ieu_bit_ops
`default_nettype wire

// ### logic/ieu_compare.sv
// Sized subtract that only produces condition flags
`timescale 1ns/1ps
`default_nettype none
module ieu_compare
  import ieu_pkg::*;
(
  // Operands
  input  wire logic [1:0]  size_i,
  input  wire logic [31:0] minuend_i,
  input  wire logic [31:0] subtrahend_i,
  // Flags N Z V C
  output logic      [3:0]  flags_o
);

  logic [31:0] a_top;   // Minuend aligned to bit 31
  logic [31:0] b_top;   // Subtrahend aligned to bit 31
  logic [32:0] diff;    // Difference with borrow

  // ************************************************************
  // Flag computation
  // ************************************************************
  // Aligning narrow operands at the top makes one 33-bit subtract
  // give correct flags for every size
  always_comb begin
    a_top = minuend_i;
    b_top = subtrahend_i;
    if (size_i == SIZE_BYTE) begin
      a_top = {minuend_i[7:0], 24'h000000};
      b_top = {subtrahend_i[7:0], 24'h000000};
    end else if (size_i == SIZE_WORD) begin
      a_top = {minuend_i[15:0], 16'h0000};
      b_top = {subtrahend_i[15:0], 16'h0000};
    end
    diff            = {1'b0, a_top} - {1'b0, b_top};
    flags_o         = 4'h0;
    flags_o[FLAG_N] = diff[31];
    flags_o[FLAG_Z] = (diff[31:0] == RST_WORD);
    flags_o[FLAG_C] = diff[32];
    flags_o[FLAG_V] = (a_top[31] ^ b_top[31]) & (a_top[31] ^ diff[31]);
  end

endmodule : ieu_compare
`default_nettype wire

// ### logic/ieu_execute_unit.sv
// Execution unit for the extended instruction set operations
`timescale 1ns/1ps
`default_nettype none
module ieu_execute_unit
  import ieu_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Operation request
  input  wire logic        start_i,
  input  wire ieu_op_type  op_i,
  input  wire logic [1:0]  size_i,
  input  wire logic [31:0] src_i,
  input  wire logic [31:0] dst_i,
  input  wire logic [31:0] imm_i,
  input  wire logic [31:0] disp_i,
  input  wire logic [31:0] pc_next_i,
  input  wire logic [31:0] sp_i,
  input  wire logic        cond_true_i,
  input  wire logic        flag_v_i,
  // Completion and register results
  output logic             busy_o,
  output logic             done_o,
  output logic             rd_we_o,
  output logic      [31:0] rd_data_o,
  output logic             flags_we_o,
  output logic      [3:0]  flags_o,
  output logic             pc_load_o,
  output logic      [31:0] pc_target_o,
  output logic             sp_we_o,
  output logic      [31:0] sp_o,
  // Data memory bus
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic             mem_lock_o,
  output logic      [1:0]  mem_size_o,
  output logic      [31:0] mem_addr_o,
  output logic      [31:0] mem_wdata_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  // Instruction cache lock port
  output logic             icl_req_o,
  output logic      [31:0] icl_addr_o,
  input  wire logic        icl_ack_i
);

  // ************************************************************
  // Reset release
  // ************************************************************
  logic rst_meta_q;   // First reset stage
  logic rst_sync_q;   // Released reset used by the design
  logic rst_n;        // Local reset

  // Two flops release the reset on the clock
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // ************************************************************
  // Datapath helpers
  // ************************************************************
  logic [31:0] rev_w;       // Bit-reversed destination
  logic [31:0] swap_w;      // Byte-swapped destination
  logic [5:0]  ff1_w;       // Find-first-one distance
  logic [3:0]  cmp_flags;   // Compare flags
  logic [31:0] cmp_rhs;     // Compare subtrahend
  logic [1:0]  cmp_size;    // Compare width

  ieu_bit_ops u_bit_ops (
    .value_i (dst_i),
    .rev_o   (rev_w),
    .swap_o  (swap_w),
    .ff1_o   (ff1_w)
  );

  // Immediate compare uses the instruction constant
  assign cmp_rhs  = (op_i == OP_COMPARE_IMM) ? imm_i : src_i;
  assign cmp_size = size_i;

  ieu_compare u_compare (
    .size_i       (cmp_size),
    .minuend_i    (dst_i),
    .subtrahend_i (cmp_rhs),
    .flags_o      (cmp_flags)
  );

  // ************************************************************
  // Control and output state
  // ************************************************************
  ieu_state_type state_q, state_d;   // Sequencer state
  logic        busy_q, busy_d;       // Multi-cycle operation running
  logic        done_q, done_d;       // Completion pulse
  logic        rd_we_q, rd_we_d;     // Register write pulse
  logic [31:0] rd_q, rd_d;           // Register result
  logic        fl_we_q, fl_we_d;     // Flag write pulse
  logic [3:0]  fl_q, fl_d;           // Flag result
  logic        pc_ld_q, pc_ld_d;     // Program counter load pulse
  logic [31:0] pc_q, pc_d;           // Branch target
  logic        sp_we_q, sp_we_d;     // Stack pointer write pulse
  logic [31:0] sp_q, sp_d;           // New stack pointer
  logic        req_q, req_d;         // Memory request
  logic        we_q, we_d;           // Memory write
  logic        lock_q, lock_d;       // Bus held indivisible
  logic [1:0]  msz_q, msz_d;         // Memory access size
  logic [31:0] addr_q, addr_d;       // Memory address
  logic [31:0] wdat_q, wdat_d;       // Memory write data
  logic        icl_q, icl_d;         // Cache lock request
  logic [31:0] icla_q, icla_d;       // Cache lock address
  logic [31:0] user_stack_pointer_q; // User stack pointer
  logic [31:0] user_stack_pointer_d;
  logic        accept;               // Request taken this cycle

  assign accept = start_i && (state_q == ST_IDLE);

  // ************************************************************
  // Next-state logic
  // ************************************************************
  // Decodes a new operation or advances a memory sequence
  always_comb begin
    state_d = state_q;
    busy_d  = busy_q;
    done_d  = 1'b0;
    rd_we_d = 1'b0;
    rd_d    = rd_q;
    fl_we_d = 1'b0;
    fl_d    = fl_q;
    pc_ld_d = 1'b0;
    pc_d    = pc_q;
    sp_we_d = 1'b0;
    sp_d    = sp_q;
    req_d   = req_q;
    we_d    = we_q;
    lock_d  = lock_q;
    msz_d   = msz_q;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    icl_d   = icl_q;
    icla_d  = icla_q;
    user_stack_pointer_d = user_stack_pointer_q;
    unique case (state_q)
      ST_IDLE: begin
        if (accept) begin
          // Single-cycle operations complete next cycle
          done_d = 1'b1;
          unique case (op_i)
            OP_BIT_REVERSE: begin
              rd_we_d = 1'b1;
              rd_d    = rev_w;
            end
            OP_BYTE_SWAP: begin
              rd_we_d = 1'b1;
              rd_d    = swap_w;
            end
            OP_FIND_FIRST_ONE: begin
              rd_we_d = 1'b1;
              rd_d    = {26'h0000000, ff1_w};
            end
            OP_QUICK_IMM_MOVE: begin
              rd_we_d = 1'b1;
              rd_d    = {{29{imm_i[2]}}, imm_i[2:0]};
            end
            OP_TO_USER_SP: begin
              user_stack_pointer_d = src_i;
            end
            OP_FROM_USER_SP: begin
              rd_we_d = 1'b1;
              rd_d    = user_stack_pointer_q;
            end
            OP_SIGN_EXT_MOVE: begin
              rd_we_d = 1'b1;
              rd_d    = ieu_sext(size_i, src_i);
            end
            OP_ZERO_EXT_MOVE: begin
              rd_we_d = 1'b1;
              rd_d    = ieu_zext(size_i, src_i);
            end
            OP_SIGNED_SAT: begin
              // Only an overflow rewrites the register
              if (flag_v_i) begin
                rd_we_d = 1'b1;
                rd_d    = dst_i[31] ? SAT_MOST_POS
                                    : SAT_MOST_NEG;
              end
            end
            OP_COMPARE, OP_COMPARE_IMM: begin
              fl_we_d = 1'b1;
              fl_d    = cmp_flags;
            end
            OP_BRANCH_LONG: begin
              pc_ld_d = cond_true_i;
              pc_d    = pc_next_i + disp_i;
            end
            OP_TEST_SET_BYTE: begin
              // Locked byte read starts the sequence
              done_d  = 1'b0;
              busy_d  = 1'b1;
              state_d = ST_TSET_RD;
              req_d   = 1'b1;
              we_d    = 1'b0;
              lock_d  = 1'b1;
              msz_d   = SIZE_BYTE;
              addr_d  = src_i;
            end
            OP_IMM_STORE_DISP: begin
              done_d  = 1'b0;
              busy_d  = 1'b1;
              state_d = ST_MEM_WR;
              req_d   = 1'b1;
              we_d    = 1'b1;
              msz_d   = size_i;
              addr_d  = src_i + disp_i;
              wdat_d  = ieu_zext(size_i, imm_i);
            end
            OP_SUBR_CALL_LONG: begin
              // Return address goes below the stack pointer
              done_d  = 1'b0;
              busy_d  = 1'b1;
              state_d = ST_PUSH;
              req_d   = 1'b1;
              we_d    = 1'b1;
              msz_d   = SIZE_LONG;
              addr_d  = sp_i - STACK_STEP;
              wdat_d  = pc_next_i;
              pc_d    = pc_next_i + disp_i;
            end
            OP_ICACHE_LOCK: begin
              done_d  = 1'b0;
              busy_d  = 1'b1;
              state_d = ST_LOCK;
              icl_d   = 1'b1;
              icla_d  = src_i;
            end
          endcase
        end
      end
      ST_TSET_RD: begin
        // Byte read back; flags from it, write with top bit set
        if (mem_ack_i) begin
          state_d              = ST_MEM_WR;
          we_d                 = 1'b1;
          wdat_d               = {24'h000000, mem_rdata_i[7:0]};
          wdat_d[TSET_BIT]     = 1'b1;
          fl_d                 = 4'h0;
          fl_d[FLAG_N]         = mem_rdata_i[TSET_BIT];
          fl_d[FLAG_Z]         = (mem_rdata_i[7:0] == 8'h00);
        end
      end
      ST_MEM_WR: begin
        // Write finishes both the store and the test-and-set
        if (mem_ack_i) begin
          state_d = ST_IDLE;
          busy_d  = 1'b0;
          done_d  = 1'b1;
          req_d   = 1'b0;
          we_d    = 1'b0;
          fl_we_d = lock_q;
          lock_d  = 1'b0;
        end
      end
      ST_PUSH: begin
        // After the push the call redirects the program counter
        if (mem_ack_i) begin
          state_d = ST_IDLE;
          busy_d  = 1'b0;
          done_d  = 1'b1;
          req_d   = 1'b0;
          we_d    = 1'b0;
          sp_we_d = 1'b1;
          sp_d    = addr_q;
          pc_ld_d = 1'b1;
        end
      end
      ST_LOCK: begin
        // Cache fills and locks the block, then acknowledges
        if (icl_ack_i) begin
          state_d = ST_IDLE;
          busy_d  = 1'b0;
          done_d  = 1'b1;
          icl_d   = 1'b0;
        end
      end
    endcase
  end

  // ************************************************************
  // State registers
  // ************************************************************
  // Registers every output so ports come straight from flops
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      rd_we_q <= 1'b0;
      rd_q    <= RST_WORD;
      fl_we_q <= 1'b0;
      fl_q    <= 4'h0;
      pc_ld_q <= 1'b0;
      pc_q    <= RST_WORD;
      sp_we_q <= 1'b0;
      sp_q    <= RST_WORD;
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      lock_q  <= 1'b0;
      msz_q   <= SIZE_BYTE;
      addr_q  <= RST_WORD;
      wdat_q  <= RST_WORD;
      icl_q   <= 1'b0;
      icla_q  <= RST_WORD;
      user_stack_pointer_q <= RST_WORD;
    end else begin
      state_q <= state_d;
      busy_q  <= busy_d;
      done_q  <= done_d;
      rd_we_q <= rd_we_d;
      rd_q    <= rd_d;
      fl_we_q <= fl_we_d;
      fl_q    <= fl_d;
      pc_ld_q <= pc_ld_d;
      pc_q    <= pc_d;
      sp_we_q <= sp_we_d;
      sp_q    <= sp_d;
      req_q   <= req_d;
      we_q    <= we_d;
      lock_q  <= lock_d;
      msz_q   <= msz_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      icl_q   <= icl_d;
      icla_q  <= icla_d;
      user_stack_pointer_q <= user_stack_pointer_d;
    end
  end

  // Output ports
  assign busy_o      = busy_q;
  assign done_o      = done_q;
  assign rd_we_o     = rd_we_q;
  assign rd_data_o   = rd_q;
  assign flags_we_o  = fl_we_q;
  assign flags_o     = fl_q;
  assign pc_load_o   = pc_ld_q;
  assign pc_target_o = pc_q;
  assign sp_we_o     = sp_we_q;
  assign sp_o        = sp_q;
  assign mem_req_o   = req_q;
  assign mem_we_o    = we_q;
  assign mem_lock_o  = lock_q;
  assign mem_size_o  = msz_q;
  assign mem_addr_o  = addr_q;
  assign mem_wdata_o = wdat_q;
  assign icl_req_o   = icl_q;
  assign icl_addr_o  = icla_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_bit_rev;
    @(posedge clock_i) disable iff (!rst_n)
    accept && op_i == OP_BIT_REVERSE |=>
      rd_we_o && rd_data_o[0] == $past(dst_i[31])
      && rd_data_o[31] == $past(dst_i[0]);
  endproperty
  a_bit_rev: assert property (p_bit_rev)
    else $error("bit reverse result wrong");

  property p_byte_swap;
    @(posedge clock_i) disable iff (!rst_n)
    accept && op_i == OP_BYTE_SWAP |=>
      rd_data_o[31:24] == $past(dst_i[7:0])
      && rd_data_o[7:0] == $past(dst_i[31:24]);
  endproperty
  a_byte_swap: assert property (p_byte_swap)
    else $error("byte swap result wrong");

  property p_ff1;
    @(posedge clock_i) disable iff (!rst_n)
    accept && op_i == OP_FIND_FIRST_ONE && dst_i[31:30] == 2'h1 |=>
      rd_we_o && rd_data_o == 32'h00000001;
  endproperty
  a_ff1: assert property (p_ff1)
    else $error("find first one distance wrong");

  property p_ff1_none;
    @(posedge clock_i) disable iff (!rst_n)
    accept && op_i == OP_FIND_FIRST_ONE && dst_i == 32'h00000000 |=>
      rd_data_o == 32'h00000020;
  endproperty
  a_ff1_none: assert property (p_ff1_none)
    else $error("empty scan must give 32");

  property p_ext;
    @(posedge clock_i) disable iff (!rst_n)
    accept && size_i == SIZE_BYTE
      && (op_i == OP_SIGN_EXT_MOVE || op_i == OP_ZERO_EXT_MOVE) |=>
      rd_data_o[31:8] == ($past(op_i) == OP_SIGN_EXT_MOVE
        ? {24{$past(src_i[7])}} : 24'h000000);
  endproperty
  a_ext: assert property (p_ext)
    else $error("byte extension wrong");

  property p_sat;
    @(posedge clock_i) disable iff (!rst_n)
    accept && op_i == OP_SIGNED_SAT |=>
      rd_we_o == $past(flag_v_i)
      && (!rd_we_o || rd_data_o[31] == !$past(dst_i[31]));
  endproperty
  a_sat: assert property (p_sat)
    else $error("saturate result wrong");

  property p_tset;
    @(posedge clock_i) disable iff (!rst_n)
    state_q == ST_TSET_RD && mem_ack_i |=>
      mem_lock_o && mem_we_o && mem_wdata_o[7]
      && mem_addr_o == $past(mem_addr_o);
  endproperty
  a_tset: assert property (p_tset)
    else $error("test and set write wrong");

  property p_cmp;
    @(posedge clock_i) disable iff (!rst_n)
    accept && (op_i == OP_COMPARE || op_i == OP_COMPARE_IMM) |=>
      flags_we_o && !rd_we_o && !mem_req_o;
  endproperty
  a_cmp: assert property (p_cmp)
    else $error("compare must only write flags");

  property p_branch;
    @(posedge clock_i) disable iff (!rst_n)
    accept && op_i == OP_BRANCH_LONG |=>
      pc_load_o == $past(cond_true_i)
      && pc_target_o == $past(pc_next_i) + $past(disp_i);
  endproperty
  a_branch: assert property (p_branch)
    else $error("long branch wrong");

  property p_store;
    @(posedge clock_i) disable iff (!rst_n)
    accept && op_i == OP_IMM_STORE_DISP |=>
      mem_req_o && mem_we_o
      && mem_addr_o == $past(src_i) + $past(disp_i);
  endproperty
  a_store: assert property (p_store)
    else $error("immediate store address wrong");

endmodule : ieu_execute_unit
`default_nettype wire

// ### bench/test_isa_extension_execute_unit.sv
// Self-checking bench for the extension execute unit
`timescale 1ns/1ps
`default_nettype none
module test_isa_extension_execute_unit;
  import ieu_pkg::*;
  logic clock_i = 0, rst_n_i = 0, start_i = 0, cond_true_i = 0;
  logic flag_v_i = 0, mem_ack_i = 0, icl_ack_i = 0;
  ieu_op_type op_i = OP_BIT_REVERSE;
  logic [1:0] size_i = 0, mem_size_o;
  logic [31:0] src_i = 0, dst_i = 0, imm_i = 0, disp_i = 0;
  logic [31:0] pc_next_i = 0, sp_i = 0, mem_rdata_i = 0, d, s, r;
  logic busy_o, done_o, rd_we_o, flags_we_o, pc_load_o, sp_we_o;
  logic mem_req_o, mem_we_o, mem_lock_o, icl_req_o;
  logic [31:0] rd_data_o, pc_target_o, sp_o, mem_addr_o, mem_wdata_o;
  logic [31:0] icl_addr_o;
  logic [3:0] flags_o;
  logic [31:0] exp_q[$]; // Expected results, oldest first
  int fails = 0, cmp_count = 0;
  ieu_execute_unit u_dut (.*);
  initial forever #50 clock_i = ~clock_i;
  // Memory and cache partner: ack one cycle after a request shows
  always @(posedge clock_i) begin
    mem_ack_i <= mem_req_o & ~mem_ack_i;
    icl_ack_i <= icl_req_o & ~icl_ack_i;
  end
  function automatic logic [31:0] rev(logic [31:0] v);
    for (int k = 0; k < 32; k++) rev[k] = v[31-k];
  endfunction : rev
  function automatic logic [31:0] ffo(logic [31:0] v);
    ffo = 32;
    for (int k = 0; k < 32; k++) if (v[k]) ffo = 31 - k;
  endfunction : ffo
  function automatic logic [31:0] msk(logic [1:0] z);
    return z == SIZE_BYTE ? 32'hFF : z == SIZE_WORD ? 32'hFFFF : '1;
  endfunction : msk
  // Sized subtract flags N Z V C
  function automatic logic [31:0] cf(logic [1:0] z, logic [31:0] a, b);
    logic [31:0] x, y;
    logic [32:0] q;
    x = a << (z == SIZE_BYTE ? 24 : 16);
    y = b << (z == SIZE_BYTE ? 24 : 16);
    q = {1'b0, x} - {1'b0, y};
    return {28'h0, q[31], q[31:0] == 0, x[31] != y[31] && q[31] != x[31], q[32]};
  endfunction : cf
  task automatic chk(logic [31:0] sv, logic [31:0] ev);
    cmp_count++;
    if (sv !== ev) begin
      fails++;
      $display("BAD %0t seen %h exp %h", $time, sv, ev);
    end
  endtask : chk
  task automatic take(logic [31:0] sv);
    if (exp_q.size() == 0) chk(sv, 'x);
    else chk(sv, exp_q.pop_front());
  endtask : take
  // Result watcher, one note per result
  always @(posedge clock_i) if (rst_n_i) begin
    if (mem_req_o && mem_ack_i && mem_we_o) begin
      chk({busy_o, mem_lock_o, mem_size_o}, {1'b1,
          op_i == OP_TEST_SET_BYTE, op_i == OP_TEST_SET_BYTE ? SIZE_BYTE
          : op_i == OP_SUBR_CALL_LONG ? SIZE_LONG : size_i});
      take(mem_addr_o);
      take(mem_wdata_o);
    end
    if (icl_req_o && icl_ack_i) begin
      chk({31'h0, busy_o}, 1);
      take(icl_addr_o);
    end
    if (rd_we_o) take(rd_data_o);
    if (flags_we_o) take({28'h0, flags_o});
    if (sp_we_o) take(sp_o);
    if (pc_load_o) take(pc_target_o);
  end
  task automatic go(ieu_op_type o, logic [1:0] z, logic [31:0] dv, sv, iv);
    @(posedge clock_i);
    {op_i, size_i, dst_i, src_i, imm_i, start_i} <= {o, z, dv, sv, iv, 1'b1};
    @(posedge clock_i);
    start_i <= 0;
    for (int k = 0; k < 40 && done_o !== 1'b1; k++) @(posedge clock_i);
    chk({31'h0, done_o}, 1);
  endtask : go
  task automatic complete_run;
    chk(exp_q.size(), 0);
    $display("cmp_count %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  initial begin
    #1000000;
    fails++;
    complete_run();
  end
  initial begin
    void'($urandom(32'hA7E6));
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1;
    repeat (4) @(posedge clock_i);
    {pc_next_i, sp_i, disp_i} <= {$urandom, $urandom, $urandom};
    for (int n = 0; n < 4; n++) begin
      d = n == 0 ? 0 : n == 1 ? 32'h80000000 : n == 2 ? $urandom
        : {2'h1, 30'($urandom)};
      s = $urandom;
      exp_q.push_back(rev(d));
      go(OP_BIT_REVERSE, SIZE_LONG, d, 0, 0);
      exp_q.push_back({d[7:0], d[15:8], d[23:16], d[31:24]});
      go(OP_BYTE_SWAP, SIZE_LONG, d, 0, 0);
      exp_q.push_back(ffo(d));
      go(OP_FIND_FIRST_ONE, SIZE_LONG, d, 0, 0);
      exp_q.push_back({{29{s[2]}}, s[2:0]});
      go(OP_QUICK_IMM_MOVE, SIZE_LONG, 0, 0, s);
      for (int z = 0; z < 2; z++) begin
        exp_q.push_back(z ? {{16{s[15]}}, s[15:0]} : {{24{s[7]}}, s[7:0]});
        go(OP_SIGN_EXT_MOVE, z[1:0], 0, s, 0);
        exp_q.push_back(s & msk(z[1:0]));
        go(OP_ZERO_EXT_MOVE, z[1:0], 0, s, 0);
        exp_q.push_back(cf(z[1:0], d, s));
        go(OP_COMPARE, z[1:0], d, s, 0);
        exp_q.push_back(cf(z[1:0], s, d));
        go(OP_COMPARE_IMM, z[1:0], s, 0, d);
      end
      flag_v_i <= n != 2;
      if (n != 2) exp_q.push_back(d[31] ? SAT_MOST_POS : SAT_MOST_NEG);
      go(OP_SIGNED_SAT, SIZE_LONG, d, 0, 0);
      $display("register test %0d done", n);
    end
    exp_q.push_back(s);
    go(OP_TO_USER_SP, SIZE_LONG, 0, s, 0);
    go(OP_FROM_USER_SP, SIZE_LONG, 0, 0, 0);
    for (int c = 0; c < 2; c++) begin
      cond_true_i <= c[0];
      if (c) exp_q.push_back(pc_next_i + disp_i);
      go(OP_BRANCH_LONG, SIZE_LONG, 0, 0, 0);
      exp_q.push_back(sp_i - 4);
      exp_q.push_back(pc_next_i);
      exp_q.push_back(sp_i - 4);
      exp_q.push_back(pc_next_i + disp_i);
      go(OP_SUBR_CALL_LONG, SIZE_LONG, 0, 0, 0);
      {s, d, r} = {$urandom, $urandom, $urandom};
      exp_q.push_back(s + disp_i);
      exp_q.push_back(d & msk(c[1:0]));
      go(OP_IMM_STORE_DISP, c[1:0], 0, s, d);
      if (c) r[7:0] = 0;
      mem_rdata_i <= r;
      exp_q.push_back(s);
      exp_q.push_back({24'h0, r[7:0] | 8'h80});
      exp_q.push_back({28'h0, r[7], r[7:0] == 0, 2'h0});
      go(OP_TEST_SET_BYTE, SIZE_BYTE, 0, s, 0);
      exp_q.push_back(d);
      go(OP_ICACHE_LOCK, SIZE_LONG, 0, d, 0);
      $display("flow test %0d done", c);
    end
    complete_run();
  end
endmodule : test_isa_extension_execute_unit
`default_nettype wire
